//--- ccd_readout_timing.sv
// Contract
// - clock at least 2740/5480 lines per frame
// - vertical rising edges lead falling edges
// - phase one drops after phase four rises
// - clock at least 4092/8172 pixels per line
// - shutter drain pulse is optional
// - line_dump_gate pulses discard lines optionally
// - dump burst then ordinary readout line
// - each pin follows its mode pattern
// - unused reset/horizontal gates held high
`include "ccd_timing_map.svh"

module ccd_readout_timing
	import ccd_timing_pkg::*;
#(
	parameter int LINES_SHORT  = `LINES_SHORT,
	parameter int LINES_LONG   = `LINES_LONG,
	parameter int PIXELS_SHORT = `PIXELS_SHORT,
	parameter int PIXELS_LONG  = `PIXELS_LONG,
	parameter int CNT_W        = 14,
	parameter int INTEG_W      = 24
)
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// control
	input  wire logic              frame_start,
	input  wire readout_mode_type  mode_sel,
	input  wire logic              shutter_en,
	input  wire logic [INTEG_W-1:0] integ_ticks,
	input  wire logic [3:0]        dump_count,
	// vertical gates (pattern levels: phase one has a third, high level)
	output logic                   vertical_phase_one,
	output logic                   vertical_phase_one_high,
	output logic                   vertical_phase_two,
	output logic                   vertical_phase_three,
	output logic                   vertical_phase_four,
	// horizontal and reset gates, one per output a..d
	output logic [3:0]             horiz_gate_one,
	output logic [3:0]             last_horizontal_gate,
	output logic [3:0]             reset_gate,
	// shutter drain and dump
	output logic                   shutter_drain,
	output logic                   line_dump_gate,
	// status
	output logic                   busy,
	output logic                   frame_done
);

	seq_state_type      state_r;
	logic [CNT_W-1:0]   line_r;
	logic [CNT_W-1:0]   pix_r;
	logic [INTEG_W-1:0] tick_r;
	logic [1:0]         vstep_r;
	logic [3:0]         dump_r;
	logic               hphase_r;
	logic               hclk_en;
	logic [CNT_W-1:0]   line_last;
	logic [CNT_W-1:0]   pix_last;
	logic [3:0]         out_used;
	logic               frame_req;

	// terminal counts from the readout mode
	always_comb
	begin
		line_last = CNT_W'(LINES_SHORT - 1);
		pix_last  = CNT_W'(PIXELS_SHORT - 1);
		out_used  = 4'hf;
		unique case (mode_sel)
			MODE_QUAD:
			begin
				out_used = 4'hf;
			end
			MODE_DUAL_AB:
			begin
				line_last = CNT_W'(LINES_LONG - 1);
				out_used  = 4'h3;
			end
			MODE_DUAL_AC:
			begin
				out_used = 4'h5;
			end
			MODE_SINGLE:
			begin
				line_last = CNT_W'(LINES_LONG - 1);
				pix_last  = CNT_W'(PIXELS_LONG - 1);
				out_used  = 4'h1;
			end
		endcase
	end

	assign frame_req = frame_start && (state_r == ST_IDLE);

	// pixel clock enable divider
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			hphase_r <= 1'b0;
		else
			hphase_r <= ~hphase_r;
	end
	assign hclk_en = hphase_r;

	// sequencer
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			line_r  <= '0;
			pix_r   <= '0;
			tick_r  <= '0;
			vstep_r <= '0;
			dump_r  <= '0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					tick_r <= '0;
					line_r <= '0;
					if (frame_req)
						state_r <= shutter_en ? ST_SHUTTER : ST_XFER;
				end
				ST_SHUTTER:
				begin
					tick_r <= tick_r + 1'b1;
					if (tick_r == INTEG_W'(`SHUTTER_TICKS - 1))
					begin
						tick_r  <= '0;
						state_r <= ST_INTEGRATE;
					end
				end
				ST_INTEGRATE:
				begin
					// integration spans drain fall to phase one fall
					tick_r <= tick_r + 1'b1;
					if (tick_r >= integ_ticks)
					begin
						tick_r  <= '0;
						state_r <= ST_XFER;
					end
				end
				ST_XFER:
				begin
					tick_r <= tick_r + 1'b1;
					if (tick_r == INTEG_W'(3 * `VPHASE_TICKS - 1))
					begin
						tick_r  <= '0;
						vstep_r <= '0;
						dump_r  <= dump_count;
						state_r <= ST_VSHIFT;
					end
				end
				ST_VSHIFT:
				begin
					tick_r <= tick_r + 1'b1;
					if (tick_r == INTEG_W'(`VPHASE_TICKS - 1))
					begin
						tick_r  <= '0;
						vstep_r <= vstep_r + 1'b1;
						if (vstep_r == 2'd3)
						begin
							pix_r <= '0;
							if (dump_r != 4'h0)
								state_r <= ST_DUMP;
							else
								state_r <= ST_HSHIFT;
						end
					end
				end
				ST_DUMP:
				begin
					tick_r <= tick_r + 1'b1;
					if (tick_r == INTEG_W'(`DUMP_TICKS - 1))
					begin
						tick_r  <= '0;
						dump_r  <= dump_r - 1'b1;
						line_r  <= line_r + 1'b1;
						state_r <= (line_r == line_last) ? ST_DONE : ST_VSHIFT;
					end
				end
				ST_HSHIFT:
				begin
					if (hclk_en)
					begin
						pix_r <= pix_r + 1'b1;
						if (pix_r == pix_last + CNT_W'(`LINE_PAD_TICKS))
						begin
							line_r  <= line_r + 1'b1;
							dump_r  <= dump_count;
							state_r <= (line_r == line_last) ? ST_DONE : ST_VSHIFT;
						end
					end
				end
				ST_DONE:
				begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// vertical phases: rise before fall in every step
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			vertical_phase_one      <= 1'b0;
			vertical_phase_one_high <= 1'b0;
			vertical_phase_two      <= 1'b0;
			vertical_phase_three    <= 1'b0;
			vertical_phase_four     <= 1'b0;
		end
		else if (state_r == ST_XFER)
		begin
			// phase one to high level, then four rises before one drops to mid
			vertical_phase_one      <= 1'b1;
			vertical_phase_one_high <= tick_r < INTEG_W'(2 * `VPHASE_TICKS);
			vertical_phase_four     <= tick_r >= INTEG_W'(2 * `VPHASE_TICKS - 1);
			vertical_phase_two      <= 1'b0;
			vertical_phase_three    <= 1'b0;
		end
		else if (state_r == ST_VSHIFT)
		begin
			// four-phase walk; next phase rises one tick ahead of the fall
			vertical_phase_one_high <= 1'b0;
			vertical_phase_one   <= (vstep_r == 2'd0) ||
				(vstep_r == 2'd3 && tick_r == INTEG_W'(`VPHASE_TICKS - 1));
			vertical_phase_two   <= (vstep_r == 2'd1) ||
				(vstep_r == 2'd0 && tick_r == INTEG_W'(`VPHASE_TICKS - 1));
			vertical_phase_three <= (vstep_r == 2'd2) ||
				(vstep_r == 2'd1 && tick_r == INTEG_W'(`VPHASE_TICKS - 1));
			vertical_phase_four  <= (vstep_r == 2'd3) ||
				(vstep_r == 2'd2 && tick_r == INTEG_W'(`VPHASE_TICKS - 1));
		end
		else
		begin
			vertical_phase_one_high <= 1'b0;
			vertical_phase_two      <= 1'b0;
			vertical_phase_three    <= 1'b0;
			vertical_phase_four     <= 1'b0;
			// phase one parks at mid level between lines
			vertical_phase_one <= (state_r == ST_DUMP) || (state_r == ST_HSHIFT);
		end
	end

	// horizontal, reset and dump gates
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			horiz_gate_one       <= 4'hf;
			last_horizontal_gate <= 4'hf;
			reset_gate           <= 4'hf;
			line_dump_gate       <= 1'b0;
			shutter_drain        <= 1'b0;
		end
		else
		begin
			if (state_r == ST_HSHIFT)
			begin
				// unused outputs park high
				horiz_gate_one       <= ~out_used | {4{hphase_r}};
				last_horizontal_gate <= ~out_used | {4{~hphase_r}};
				reset_gate           <= ~out_used | {4{~hphase_r}};
			end
			else
			begin
				horiz_gate_one       <= 4'hf;
				last_horizontal_gate <= 4'hf;
				reset_gate           <= 4'hf;
			end
			line_dump_gate <= (state_r == ST_DUMP);
			shutter_drain  <= (state_r == ST_SHUTTER);
		end
	end

	// status
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busy       <= 1'b0;
			frame_done <= 1'b0;
		end
		else
		begin
			busy       <= (state_r != ST_IDLE) || frame_req;
			frame_done <= (state_r == ST_DONE);
		end
	end

endmodule

//--- ccd_readout_timing_bench.sv
module ccd_readout_timing_bench import ccd_timing_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, sys_rst, frame_start, shutter_en, clr;
	readout_mode_type mode_sel;
	logic [23:0] integ_ticks;
	logic [3:0] dump_count, horiz_gate_one, last_horizontal_gate, reset_gate;
	logic vertical_phase_one, vertical_phase_one_high, vertical_phase_two;
	logic vertical_phase_three, vertical_phase_four, shutter_drain, line_dump_gate;
	logic busy, frame_done;
	int n_fail, tests_run, seed, t, k, rows, xfers, max_pix, integ, dumps;
	ccd_readout_timing #(.LINES_SHORT(4), .LINES_LONG(8), .PIXELS_SHORT(8),
		.PIXELS_LONG(16)) dut (.*);
	sensor_model model (.*);
	initial
	begin
		core_clk = 1'b0;
		forever
			#25 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d fails %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic int exp_lines(readout_mode_type m);
		return (m == MODE_DUAL_AB || m == MODE_SINGLE) ? 8 : 4;
	endfunction
	// start sent again mid-frame must be ignored
	task automatic frame(input readout_mode_type m, input logic se, input logic [3:0] dc);
		@(posedge core_clk);
		#2;
		mode_sel = m;
		shutter_en = se;
		dump_count = dc;
		integ_ticks = 24'($random(seed)) & 24'h3f;
		clr = 1'b1;
		frame_start = 1'b1;
		@(posedge core_clk);
		#2;
		clr = 1'b0;
		frame_start = 1'b0;
		repeat (30) @(posedge core_clk);
		#2 frame_start = 1'b1;
		@(posedge core_clk);
		#2 frame_start = 1'b0;
		t = 0;
		while (frame_done !== 1'b1 && t < 8000)
		begin
			@(posedge core_clk);
			#2;
			t++;
		end
		// a frame that never ends counts as a mismatch
		check(t < 8000, 1);
		repeat (40) @(posedge core_clk);
		#2;
		check(busy, 1'b0);
		check(xfers, 1);
		check(rows >= exp_lines(m), 1);
		// a burst as long as the frame leaves no line to read out
		check(max_pix >= ((m == MODE_SINGLE) ? 16 : 8), dc < exp_lines(m));
		check(dumps > 0, dc != 4'h0);
		if (se)
			check(integ >= integ_ticks && integ <= integ_ticks + 40, 1);
	endtask
	initial
	begin
		#(80000 * 50);
		n_fail++;
		print_verdict();
	end
	initial
	begin
		seed = 96;
		n_fail = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		frame_start = 1'b0;
		mode_sel = MODE_QUAD;
		shutter_en = 1'b0;
		integ_ticks = 24'h0;
		dump_count = 4'h0;
		clr = 1'b0;
		repeat (10) @(posedge core_clk);
		#2 sys_rst = 1'b0;
		check(reset_gate, 4'hf);
		for (k = 0; k < 4; k++)
			frame(readout_mode_type'(k), 1'b1, 4'h0);
		frame(MODE_QUAD, 1'b0, 4'h2);
		repeat (4)
			frame(readout_mode_type'(2'($random(seed))), 1'($random(seed)), 4'($random(seed)));
		print_verdict();
	end
endmodule

//--- ccd_readout_timing_checker.sv
module ccd_readout_timing_checker
	import ccd_timing_pkg::*;
(
	// clock and reset
	input wire logic             core_clk,
	input wire logic             sys_rst,
	// control
	input wire logic             frame_start,
	input wire readout_mode_type mode_sel,
	input wire logic             shutter_en,
	input wire logic [3:0]       dump_count,
	// gates
	input wire logic             vertical_phase_one,
	input wire logic             vertical_phase_one_high,
	input wire logic             vertical_phase_two,
	input wire logic             vertical_phase_three,
	input wire logic             vertical_phase_four,
	input wire logic [3:0]       horiz_gate_one,
	input wire logic [3:0]       last_horizontal_gate,
	input wire logic [3:0]       reset_gate,
	input wire logic             shutter_drain,
	input wire logic             line_dump_gate,
	// status
	input wire logic             busy,
	input wire logic             frame_done
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [4:0] sd_cnt_r;
	logic [3:0] um;
	// outputs that the selected mode leaves unused
	assign um = (mode_sel == MODE_SINGLE) ? 4'he : (mode_sel == MODE_DUAL_AB) ? 4'hc :
		(mode_sel == MODE_DUAL_AC) ? 4'ha : 4'h0;
	always_ff @(posedge core_clk or posedge sys_rst)
		if (sys_rst)
			sd_cnt_r <= 5'h0;
		else
			sd_cnt_r <= shutter_drain ? sd_cnt_r + 5'h1 : 5'h0;
	a_unused_high:
	assert property (busy |-> (reset_gate & um) == um && (last_horizontal_gate & um) == um)
		else $error("unused gate not parked high");
	a_horiz_parked:
	assert property (busy |-> (horiz_gate_one & um) == um)
		else $error("unused first horizontal gate not parked high");
	a_shutter_width:
	assert property ($fell(shutter_drain) |-> sd_cnt_r == 5'h14)
		else $error("shutter pulse width wrong");
	a_shutter_gated:
	assert property ($rose(shutter_drain) |-> shutter_en)
		else $error("shutter pulse while disabled");
	a_start_taken:
	assert property (!busy && frame_start |=> busy)
		else $error("start not taken");
	a_done_single:
	assert property (frame_done |=> !frame_done)
		else $error("done longer than one cycle");
	a_phase_lead:
	assert property ($fell(vertical_phase_one_high) |-> vertical_phase_four)
		else $error("phase one left high level before phase four rose");
	a_two_lead:
	assert property ($fell(vertical_phase_two) |-> vertical_phase_three)
		else $error("phase two fell before phase three rose");
	a_three_lead:
	assert property ($fell(vertical_phase_three) |-> vertical_phase_four)
		else $error("phase three fell before phase four rose");
	a_four_lead:
	assert property ($fell(vertical_phase_four) |-> vertical_phase_one)
		else $error("phase four fell before phase one rose");
	a_dump_width:
	assert property ($rose(line_dump_gate) |-> line_dump_gate[*8])
		else $error("dump pulse too short");
	a_dump_none:
	assert property (busy && dump_count == 4'h0 |-> !line_dump_gate)
		else $error("dump without request");
	a_idle_quiet:
	assert property (!busy |=> !line_dump_gate && !vertical_phase_one_high)
		else $error("gates active while idle");
endmodule

bind ccd_readout_timing ccd_readout_timing_checker chk (.*);

//--- ccd_timing_map.svh
`ifndef CCD_TIMING_MAP_SVH
`define CCD_TIMING_MAP_SVH

`define CLK_HZ            20000000
`define LINES_SHORT       2740
`define LINES_LONG        5480
`define PIXELS_SHORT      4092
`define PIXELS_LONG       8172
`define HCLK_DIV          2
`define VPHASE_TICKS      4
`define DUMP_TICKS        8
`define SHUTTER_TICKS     20
`define LINE_PAD_TICKS    4

`endif

//--- ccd_timing_pkg.sv
package ccd_timing_pkg;

	typedef enum logic [1:0]
	{
		MODE_QUAD,
		MODE_DUAL_AB,
		MODE_DUAL_AC,
		MODE_SINGLE
	} readout_mode_type;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_SHUTTER,
		ST_INTEGRATE,
		ST_XFER,
		ST_VSHIFT,
		ST_DUMP,
		ST_HSHIFT,
		ST_DONE
	} seq_state_type;

endpackage

//--- sensor_model.sv
module sensor_model
(
	// clock and frame clear
	input  wire logic       core_clk,
	input  wire logic       clr,
	// gate pins
	input  wire logic       vertical_phase_one,
	input  wire logic       vertical_phase_one_high,
	input  wire logic [3:0] last_horizontal_gate,
	input  wire logic       shutter_drain,
	input  wire logic       line_dump_gate,
	// what the array saw
	output int              rows,
	output int              xfers,
	output int              max_pix,
	output int              integ,
	output int              dumps
);
	timeunit 1ns;
	timeprecision 1ns;
	logic v1_q, vh_q, h2_q, sd_q, dg_q;
	int   pix, run;
	always @(posedge core_clk)
	begin
		{v1_q, vh_q, h2_q, sd_q, dg_q} <= {vertical_phase_one, vertical_phase_one_high,
			last_horizontal_gate[0], shutter_drain, line_dump_gate};
		run <= (sd_q && !shutter_drain) ? 0 : run + 1;
		if (clr)
		begin
			rows <= 0;
			xfers <= 0;
			max_pix <= 0;
			dumps <= 0;
			pix <= 0;
		end
		else
		begin
			// dummy row and first dark row land as one row
			if (v1_q && !vertical_phase_one)
				rows <= rows + 1;
			if (vh_q && !vertical_phase_one_high)
				xfers <= xfers + 1;
			if (vh_q && !vertical_phase_one_high)
				integ <= run;
			if (!dg_q && line_dump_gate)
				dumps <= dumps + 1;
			if (v1_q && !vertical_phase_one)
				pix <= 0;
			else if (h2_q && !last_horizontal_gate[0])
				pix <= pix + 1;
			if (pix > max_pix)
				max_pix <= pix;
		end
	end
endmodule
